// [hw/sbs_cfg.svh]
// Constants for the serial buffer status block: register map, bit positions, sizes.
// Assumes inclusion by bare name from design files.
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_ADDR_W        12
`define SBS_OFF_STATUS    12'h000
`define SBS_OFF_CONTROL   12'h004
`define SBS_OFF_DATA      12'h008
`define SBS_OFF_PTRS      12'h00c
`define SBS_BIT_RXFULL    0
`define SBS_BIT_TXFULL    1
`define SBS_BIT_UNUSED    2
`define SBS_BIT_TXEMPTY   3
`define SBS_CTL_ENHANCED  0
`define SBS_FIFO_DEPTH    4
`define SBS_DATA_W        32
`define SBS_PTR_W         2
`define SBS_STD_SLOT      0
`endif

// [hw/sbs_pkg.sv]
// Types shared by the serial buffer status block.
// Assumes sbs_cfg.svh constants are available to users of the package.
package sbs_pkg;
  typedef enum logic {
    SBS_MODE_STANDARD,
    SBS_MODE_ENHANCED
  } sbs_mode_t;
endpackage : sbs_pkg

// [hw/sbs_ptr_ring.sv]
// Wrap-around pointer for the enhanced buffer FIFO.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sbs_ptr_ring #(
  parameter int PTR_W = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             clear,
  input  wire logic             step,
  output logic      [PTR_W-1:0] ptr
);
  logic [PTR_W-1:0] next_ptr;

  always_comb begin
    next_ptr = ptr;
    if (clear) begin
      next_ptr = '0;
    end else if (step) begin
      next_ptr = ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end
endmodule : sbs_ptr_ring
`default_nettype wire

// [hw/sbs_apb_slave.sv]
// APB slave front end: decodes one-word registers, zero-wait answer.
// Assumes APB master on mclk; the core decides which offsets are valid.
`timescale 1ns/10ps
`default_nettype none
module sbs_apb_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              hit,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   wrStb,
  output logic                   rdStb,
  output logic      [ADDR_W-1:0] regAddr
);
  // Single access cycle; strobes fire only at the completing edge
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wrStb   = psel & penable & pwrite & hit;
  assign rdStb   = psel & penable & ~pwrite & hit;
  assign regAddr = paddr;
endmodule : sbs_apb_slave
`default_nettype wire

// [hw/sbs_status.sv]
// Buffer status flags for a serial engine's transmit and receive holding buffers.
// Assumes APB master on mclk; serial engine gives one-cycle pulses on mclk.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_status #(
  parameter int DEPTH  = `SBS_FIFO_DEPTH,
  parameter int DATA_W = `SBS_DATA_W
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SBS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   txLoadShift,
  output logic      [DATA_W-1:0]      txShiftData,
  input  wire logic                   rxStoreShift,
  input  wire logic [DATA_W-1:0]      rxShiftData,
  output logic                        enhancedMode
);
  localparam int PTR_W = $clog2(DEPTH);

  logic                   wrStb;
  logic                   rdStb;
  logic [`SBS_ADDR_W-1:0] regAddr;
  logic                   hit;
  logic                   portWr;
  logic                   portRd;
  logic                   modeWr;
  sbs_pkg::sbs_mode_t     mode;
  sbs_pkg::sbs_mode_t     next_mode;
  logic                   txEmpty;
  logic                   next_txEmpty;
  logic                   txFullStd;
  logic                   next_txFullStd;
  logic                   rxFullStd;
  logic                   next_rxFullStd;
  logic [DATA_W-1:0]      txMem [DEPTH];
  logic [DATA_W-1:0]      rxMem [DEPTH];
  logic [DATA_W-1:0]      next_txShiftData;
  logic [PTR_W-1:0]       coreWrPtr;
  logic [PTR_W-1:0]       serRdPtr;
  logic [PTR_W-1:0]       serWrPtr;
  logic [PTR_W-1:0]       coreRdPtr;
  logic                   txFull;
  logic                   rxFull;
  logic                   txEmptyEnh;
  logic                   rxEmptyEnh;
  logic [31:0]            statusWord;
  logic [31:0]            next_prdata;
  logic [31:0]            prdataQ;
  logic                   txWrEn;
  logic                   rxWrEn;
  logic [PTR_W-1:0]       txWrIdx;
  logic [PTR_W-1:0]       rxWrIdx;
  logic [PTR_W-1:0]       txRdIdx;
  logic [PTR_W-1:0]       rxRdIdx;

  // Ring full test shared by both directions
  function automatic logic ringFull(input logic [PTR_W-1:0] wr, input logic [PTR_W-1:0] rd);
    ringFull = ((wr + 1'b1) == rd);
  endfunction : ringFull

  assign hit = (paddr == `SBS_OFF_STATUS) | (paddr == `SBS_OFF_CONTROL) |
               (paddr == `SBS_OFF_DATA) | (paddr == `SBS_OFF_PTRS);

  sbs_apb_slave #(
    .ADDR_W (`SBS_ADDR_W)
  ) u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .hit     (hit),
    .pready  (pready),
    .pslverr (pslverr),
    .wrStb   (wrStb),
    .rdStb   (rdStb),
    .regAddr (regAddr)
  );

  assign portWr = wrStb & (regAddr == `SBS_OFF_DATA);
  assign portRd = rdStb & (regAddr == `SBS_OFF_DATA);
  assign modeWr = wrStb & (regAddr == `SBS_OFF_CONTROL);
  assign enhancedMode = (mode == sbs_pkg::SBS_MODE_ENHANCED);

  // Enhanced mode pointers; a mode change flushes both rings
  logic txPush;
  logic txPop;
  logic rxPush;
  logic rxPop;
  assign txPush = portWr & enhancedMode & ~txFull;
  assign txPop  = txLoadShift & enhancedMode & ~txEmptyEnh;
  assign rxPush = rxStoreShift & enhancedMode & ~rxFull;
  assign rxPop  = portRd & enhancedMode & ~rxEmptyEnh;

  sbs_ptr_ring #(.PTR_W(PTR_W)) u_cwp (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (modeWr),
    .step  (txPush),
    .ptr   (coreWrPtr)
  );
  sbs_ptr_ring #(.PTR_W(PTR_W)) u_srp (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (modeWr),
    .step  (txPop),
    .ptr   (serRdPtr)
  );
  sbs_ptr_ring #(.PTR_W(PTR_W)) u_swp (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (modeWr),
    .step  (rxPush),
    .ptr   (serWrPtr)
  );
  sbs_ptr_ring #(.PTR_W(PTR_W)) u_crp (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (modeWr),
    .step  (rxPop),
    .ptr   (coreRdPtr)
  );

  assign txEmptyEnh = (coreWrPtr == serRdPtr);
  assign rxEmptyEnh = (serWrPtr == coreRdPtr);

  // Flag sources by mode
  assign txFull = enhancedMode ? ringFull(coreWrPtr, serRdPtr) : txFullStd;
  assign rxFull = enhancedMode ? ringFull(serWrPtr, coreRdPtr) : rxFullStd;

  always_comb begin
    next_mode = mode;
    if (modeWr) begin
      next_mode = pwdata[`SBS_CTL_ENHANCED] ? sbs_pkg::SBS_MODE_ENHANCED : sbs_pkg::SBS_MODE_STANDARD;
    end
  end

  // Core write loses to nothing here: a same-cycle engine load takes the old word,
  // so the new word still sits in the holding buffer and the flags say so.
  always_comb begin
    next_txEmpty   = txEmpty;
    next_txFullStd = txFullStd;
    if (modeWr) begin
      next_txEmpty   = 1'b1;
      next_txFullStd = 1'b0;
    end else begin
      if (txLoadShift) begin
        next_txEmpty = 1'b1;
        if (!enhancedMode) begin
          next_txFullStd = 1'b0;
        end
      end
      if (portWr) begin
        next_txEmpty = 1'b0;
        if (!enhancedMode) begin
          next_txFullStd = 1'b1;
        end
      end
      if (enhancedMode && txLoadShift) begin
        next_txEmpty = portWr ? 1'b0 : ((serRdPtr + 1'b1) == coreWrPtr) | txEmptyEnh;
      end
    end
  end

  // Receive flag: set wins over a read clear when both land together; a control write clears it regardless
  always_comb begin
    next_rxFullStd = rxFullStd;
    if (modeWr) begin
      next_rxFullStd = 1'b0;
    end else begin
      if (!enhancedMode && portRd) begin
        next_rxFullStd = 1'b0;
      end
      if (!enhancedMode && rxStoreShift) begin
        next_rxFullStd = 1'b1;
      end
    end
  end

  // Standard mode uses one slot, so a single index path serves both modes
  assign txWrEn  = portWr & (~enhancedMode | ~txFull);
  assign rxWrEn  = rxStoreShift & (~enhancedMode | ~rxFull);
  assign txWrIdx = enhancedMode ? coreWrPtr : PTR_W'(`SBS_STD_SLOT);
  assign rxWrIdx = enhancedMode ? serWrPtr : PTR_W'(`SBS_STD_SLOT);
  assign txRdIdx = enhancedMode ? serRdPtr : PTR_W'(`SBS_STD_SLOT);
  assign rxRdIdx = enhancedMode ? coreRdPtr : PTR_W'(`SBS_STD_SLOT);

  always_comb begin
    next_txShiftData = txShiftData;
    if (txLoadShift) begin
      next_txShiftData = txMem[txRdIdx];
    end
  end

  // Holding storage has no reset: the flags alone say whether a slot is valid
  always_ff @(posedge mclk) begin
    if (txWrEn) begin
      txMem[txWrIdx] <= pwdata[DATA_W-1:0];
    end
    if (rxWrEn) begin
      rxMem[rxWrIdx] <= rxShiftData;
    end
  end

  // Status word: unused bit and upper bits fixed at zero
  always_comb begin
    statusWord                   = 32'h0000_0000;
    statusWord[`SBS_BIT_TXEMPTY] = txEmpty;
    statusWord[`SBS_BIT_UNUSED]  = 1'b0;
    statusWord[`SBS_BIT_TXFULL]  = txFull;
    statusWord[`SBS_BIT_RXFULL]  = rxFull;
  end

  // Status writes are decoded but never reach the flags.
  // Read data is captured in the setup cycle so it stands through the access phase;
  // an engine pulse during the access phase shows on the next read.
  always_comb begin
    next_prdata = prdataQ;
    if (psel && !penable) begin
      if (!pwrite) begin
        unique case (regAddr)
          `SBS_OFF_STATUS:  next_prdata = statusWord;
          `SBS_OFF_CONTROL: next_prdata = {31'h0000_0000, enhancedMode};
          `SBS_OFF_DATA:    next_prdata = 32'(rxMem[rxRdIdx]);
          `SBS_OFF_PTRS:    next_prdata = 32'({coreRdPtr, serWrPtr, serRdPtr, coreWrPtr});
          default:          next_prdata = 32'h0000_0000;
        endcase
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode <= sbs_pkg::SBS_MODE_STANDARD;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txEmpty   <= 1'b1;
      txFullStd <= 1'b0;
    end else begin
      txEmpty   <= next_txEmpty;
      txFullStd <= next_txFullStd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxFullStd <= 1'b0;
    end else begin
      rxFullStd <= next_rxFullStd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txShiftData <= '0;
    end else begin
      txShiftData <= next_txShiftData;
    end
  end

  assign prdata = prdataQ;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdataQ <= 32'h0000_0000;
    end else begin
      prdataQ <= next_prdata;
    end
  end
endmodule : sbs_status
`default_nettype wire

// [verification/sbs_status_props.sv]
// Checker of APB answer, mode register and status read-back.
// Assumes binding to sbs_status, one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_status_props (
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`SBS_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   enhancedMode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence acc_s; psel && penable; endsequence
  sequence ctl_s; acc_s ##0 pwrite && paddr == `SBS_OFF_CONTROL; endsequence
  sequence st_s; acc_s ##0 !pwrite && paddr == `SBS_OFF_STATUS; endsequence
  zero_wait_a: assert property (acc_s |-> pready) else $error("pready low in access");
  mapped_ok_a: assert property (acc_s ##0 paddr <= `SBS_OFF_PTRS |-> !pslverr) else $error("error on mapped");
  unmapped_err_a: assert property (acc_s ##0 paddr > `SBS_OFF_PTRS |-> pslverr) else $error("no error");
  mode_load_a: assert property (ctl_s |=> enhancedMode == $past(pwdata[0])) else $error("mode not loaded");
  mode_hold_a: assert property (!(psel && penable && pwrite && paddr == `SBS_OFF_CONTROL) |=> $stable(enhancedMode))
    else $error("mode moved");
  reset_clean_a: assert property ($rose(rst_b) |-> prdata == 0 && !enhancedMode) else $error("reset state");
  status_pad_a: assert property (st_s |=> prdata[31:4] == 0 && !prdata[2]) else $error("pad bits");
  std_flags_a: assert property (st_s ##0 !enhancedMode |=> prdata[3] != prdata[1]) else $error("flags");
endmodule : sbs_status_props
bind sbs_status sbs_status_props sbs_status_props_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .enhancedMode(enhancedMode));
`default_nettype wire

// [verification/sbs_engine_model.sv]
// Serial engine stand-in: one-cycle load and store pulses on request.
// Assumes requests driven on mclk rising edges.
`timescale 1ns/10ps
`default_nettype none
module sbs_engine_model (
  input  wire logic        mclk,
  input  wire logic        reqTx,
  input  wire logic        reqRx,
  input  wire logic [31:0] word,
  output logic             txLoadShift,
  output logic             rxStoreShift,
  output logic      [31:0] rxShiftData
);
  initial begin
    txLoadShift = 1'b0;
    rxStoreShift = 1'b0;
    rxShiftData = 32'h0;
  end
  // Idle data toggles so a stale word never passes for a stored one
  always @(posedge mclk) begin
    txLoadShift <= reqTx;
    rxStoreShift <= reqRx;
    rxShiftData <= reqRx ? word : ~rxShiftData;
  end
endmodule : sbs_engine_model
`default_nettype wire

// [verification/sbs_status_bench.sv]
// Self-checking bench for the buffer status flags.
// Assumes sbs_status with zero-wait APB and the engine model.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_status_bench;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        reqTx = 1'b0;
  logic        reqRx = 1'b0;
  logic [31:0] word = 32'h0;
  logic [31:0] prdata, txShiftData, rxShiftData, rdv;
  logic        pready, pslverr, txLoadShift, rxStoreShift, enhancedMode, errv;
  int          checks = 0;
  int          nErrors = 0;
  int          cyc = 0;
  // Row table: action and the low status nibble it should leave
  logic [2:0]  act [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [3:0]  expv [5] = '{4'h2, 4'h8, 4'h9, 4'h9, 4'h8};
  always #5 mclk = ~mclk;
  sbs_status #(.DEPTH(4), .DATA_W(32)) sbs_status_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txLoadShift(txLoadShift), .txShiftData(txShiftData),
    .rxStoreShift(rxStoreShift), .rxShiftData(rxShiftData), .enhancedMode(enhancedMode));
  sbs_engine_model sbs_engine_model_inst (.mclk(mclk), .reqTx(reqTx), .reqRx(reqRx), .word(word),
    .txLoadShift(txLoadShift), .rxStoreShift(rxStoreShift), .rxShiftData(rxShiftData));
  task report_and_stop();
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      nErrors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk
  // Read data stands from the setup cycle; taken at the completing edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    errv = pslverr;
    rdv = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task eng(input logic tx, input logic rx, input logic [31:0] w);
    reqTx <= tx; reqRx <= rx; word <= w;
    @(posedge mclk);
    reqTx <= 1'b0; reqRx <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : eng
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nErrors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(rdv, 32'h8);
    for (int i = 0; i < 5; i++) begin
      case (act[i])
        3'h0: apb(1'b1, `SBS_OFF_DATA, 32'hc0de_0001);
        3'h1: eng(1'b1, 1'b0, 32'h0);
        3'h2: eng(1'b0, 1'b1, 32'h5a5a_1234);
        3'h3: begin apb(1'b0, `SBS_OFF_DATA, 32'h0); chk(rdv, 32'h5a5a_1234); end
        default: apb(1'b1, `SBS_OFF_STATUS, 32'hffff_ffff);
      endcase
      apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(rdv, {28'h0, expv[i]});
    end
    chk(txShiftData, 32'hc0de_0001);
    $display("standard table done");
    apb(1'b1, `SBS_OFF_CONTROL, 32'h1);
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, `SBS_OFF_DATA, 32'(i));
      apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(32'(rdv[1]), 32'(i == 3));
    end
    eng(1'b1, 1'b0, 32'h0);
    apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(32'(rdv[1]), 32'h0);
    for (int i = 1; i < 4; i++) begin
      eng(1'b0, 1'b1, 32'(i));
      apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(32'(rdv[0]), 32'(i == 3));
    end
    $display("enhanced pointers done");
    apb(1'b0, 12'h010, 32'h0); chk(32'(errv), 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `SBS_OFF_STATUS, 32'h0); chk(rdv, 32'h8);
    chk(32'(enhancedMode), 32'h0);
    $display("refusal and reset done");
    report_and_stop();
  end
endmodule : sbs_status_bench
`default_nettype wire
